// ===== hw/latch_port_cfg.svh
// Purpose: offsets, field positions and sizes of the readout port
// Assumes: offsets are byte offsets within the module window
// Notes:   definitions only
`ifndef LATCH_PORT_CFG_SVH
`define LATCH_PORT_CFG_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_CONTROL     12'h000
`define OFS_IRQ         12'h004
`define OFS_CHAIN       12'h080
`define OFS_FIFO_LO     12'h100
`define OFS_FIFO_HI     12'h1FC
`define OFS_KEY_LO      12'h030
`define OFS_KEY_HI      12'h03C

// ----------------------------------------
// chained transfer setup fields
// ----------------------------------------
`define CHAIN_MASK      32'hFF00F807
`define CHAIN_ENABLE    0
`define CHAIN_LAST      1
`define CHAIN_FIRST     2

// ----------------------------------------
// control set/clear pairs and status bits
// ----------------------------------------
`define CTL_TEST_ON     1
`define CTL_TEST_OFF    9
`define CTL_BC_EN       6
`define CTL_BC_EN_OFF   14
`define CTL_BC_HS       7
`define CTL_BC_HS_OFF   15
`define CTL_SRC_ON_LSB  20
`define CTL_SRC_OFF_LSB 28
`define ST_EMPTY        8
`define ST_HALF         9
`define ST_ALMOST       10
`define ST_FULL         11
`define ST_IRQ_FLAG     15

// ----------------------------------------
// interrupt register and fifo sizes
// ----------------------------------------
`define IRQ_RW_MASK     32'h00000FFF
`define IRQ_GLOBAL      11
`define FIFO_DEPTH      64
`define FIFO_HALF       7'h20
`define FIFO_ALMOST     7'h38

`endif

// ===== hw/latch_port_pkg.sv
// Purpose: types of the readout port
// Assumes: sizes as in latch_port_cfg.svh
// Notes:   none
package latch_port_pkg;

    typedef struct packed {
        logic [31:0] chain;
        logic        test_mode;
        logic        bc_en;
        logic        bc_hs;
        logic [3:0]  src_en;
        logic [11:0] irq_ctl;
        logic [6:0]  count;
        logic [5:0]  rd_ptr;
        logic [5:0]  wr_ptr;
        logic        d16_second;
        logic        ack_hold;
        logic        dtack;
        logic        berr;
        logic [31:0] rdata;
        logic [3:0]  bcast_cmd;
    } port_state_t;

    typedef struct packed {
        logic [1:0]  count;
        logic        head;
        logic [31:0] word0;
        logic [31:0] word1;
    } skid_state_t;

endpackage

// ===== hw/event_skid.sv
// Purpose: two-entry buffer between the latch front end and the fifo
// Assumes: single clock, synchronous reset
// Notes:   a stall on the drain side holds both words
`timescale 1ns/100ps
module event_skid (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        in_valid,
    input  wire logic [31:0] in_data,
    output logic             in_ready,
    output logic             out_valid,
    output logic [31:0]      out_data,
    input  wire logic        out_ready
);
    latch_port_pkg::skid_state_t s;
    latch_port_pkg::skid_state_t next_s;
    logic                        take;
    logic                        give;

    assign in_ready  = s.count != 2'h2;
    assign out_valid = s.count != 2'h0;
    assign out_data  = s.head ? s.word1 : s.word0;
    assign take      = in_valid & in_ready;
    assign give      = out_valid & out_ready;

    always_comb begin
        next_s = s;
        if (take) begin
            // tail slot is head plus count
            if (s.head ^ s.count[0])
                next_s.word1 = in_data;
            else
                next_s.word0 = in_data;
        end
        if (give)
            next_s.head = ~s.head;
        next_s.count = s.count + {1'b0, take} - {1'b0, give};
    end

    always_ff @(posedge clk) begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    skid_no_loss_a: assert property ((s.count == 2'h2 && !out_ready) |=> s.count == 2'h2)
        else $error("buffer lost a word while stalled");
endmodule

// ===== hw/latch_readout_port.sv
// Purpose: bus slave readout side of a 32-channel event latch
// Assumes: bus_req is a one-cycle strobe per data transfer, synchronous to clk
// Notes:   unmapped addresses get no answer, as a bus slave would stay silent
//
// How it works
// - chain setup bits 31-24 match chain cycles
// - chain setup bits 15-11 hold slot address
// - chain cycles answered only when bit 0 set
// - whole window 0x100-0x1FC reads fifo output
// - fixed or incrementing block reads both served
// - test mode writes to window push fifo
// - broadcast class from high address bits
// - broadcast heeded only with enable bit 6
// - handshake controller bit 7 answers broadcast
// - four key offsets 0x30-0x3C trigger commands
// - key 0x34 next clock, 0x30 clear
// - broadcast absent in firmware version two
// - sources: copy in progress, half, almost, full
// - 8-bit vector, released on acknowledge
// - each source has enable/disable pair
// - request needs global enable bit 11
// - internal flag readable with requests off
// - level bits 8-10, vector bits 0-7
// - 16-bit reads give high half first
// - vector driven on D7-D0 at acknowledge
`timescale 1ns/100ps
`include "latch_port_cfg.svh"
module latch_readout_port #(
    parameter logic [3:0]  FW_VERSION = 4'h1,
    parameter logic [15:0] MODULE_ID  = 16'h1234  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [19:0] base_addr,
    input  wire logic        bus_req,
    input  wire logic        bus_write,
    input  wire logic        bus_d16,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_dtack,
    output logic             bus_berr,
    output logic [31:0]      bus_rdata,
    input  wire logic        iack_req,
    input  wire logic [2:0]  iack_level,
    output logic             irq_request,
    output logic [2:0]       irq_level,
    output logic             irq_flag,
    input  wire logic        event_valid,
    input  wire logic [31:0] event_data,
    output logic             event_ready,
    input  wire logic        copy_in_progress,
    output logic             fifo_empty,
    output logic             fifo_half,
    output logic             fifo_almost,
    output logic             fifo_full,
    output logic             chain_first,
    output logic             chain_last,
    output logic [3:0]       bcast_cmd
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // set wins over clear when software writes both
    function automatic logic jk(input logic cur, input logic on, input logic off);
        jk = on ? 1'b1 : (off ? 1'b0 : cur);
    endfunction

    // ----------------------------------------
    // state and fifo storage
    // ----------------------------------------
    latch_port_pkg::port_state_t s;
    latch_port_pkg::port_state_t next_s;
    logic [31:0] fifo_mem [0:`FIFO_DEPTH-1];
    logic [31:0] fifo_head;
    logic [31:0] push_word;
    logic        push;
    logic        pop;
    logic        push_test;
    logic        skid_valid;
    logic [31:0] skid_data;
    logic        skid_ready;
    logic [11:0] offset;
    logic        local_hit;
    logic        win_hit;
    logic        chain_hit;
    logic        key_hit;
    logic        bc_hit;
    logic [3:0]  sources;
    logic        pending;
    logic        iack_hit;
    logic [31:0] status_word;

    assign fifo_head   = fifo_mem[s.rd_ptr];
    assign fifo_empty  = s.count == 7'h00;
    assign fifo_half   = s.count >= `FIFO_HALF;
    assign fifo_almost = s.count >= `FIFO_ALMOST;
    assign fifo_full   = s.count == 7'(`FIFO_DEPTH);

    assign offset    = bus_addr[11:0];
    assign local_hit = bus_addr[31:12] == base_addr;
    assign win_hit   = in_range(offset, `OFS_FIFO_LO, `OFS_FIFO_HI);
    assign chain_hit = s.chain[`CHAIN_ENABLE] && !bus_write && bus_addr[31:24] == s.chain[31:24];
    assign key_hit   = in_range(offset, `OFS_KEY_LO, `OFS_KEY_HI) && offset[1:0] == 2'h0;
    // modules share the upper class and differ in the switch bits below
    assign bc_hit    = FW_VERSION == 4'h1 && s.bc_en && bus_write && key_hit
                       && bus_addr[31:16] == base_addr[19:4] && bus_addr[15:12] != base_addr[3:0];

    // ----------------------------------------
    // interrupt sources
    // ----------------------------------------
    assign sources     = {fifo_full, fifo_almost, fifo_half, copy_in_progress};
    assign pending     = |(sources & s.src_en);
    assign irq_flag    = pending;
    assign irq_level   = s.irq_ctl[10:8];
    assign irq_request = s.irq_ctl[`IRQ_GLOBAL] && pending && !s.ack_hold;
    assign iack_hit    = iack_req && irq_request && iack_level == irq_level;

    assign status_word = {8'h00, s.src_en, 4'h0, pending, 3'h0, fifo_full, fifo_almost, fifo_half,
                          fifo_empty, s.bc_hs, s.bc_en, 4'h0, s.test_mode, 1'b0};

    // test writes take the fifo port, so events wait in the buffer that cycle
    assign skid_ready = !fifo_full && !push_test;
    assign chain_first = s.chain[`CHAIN_FIRST];
    assign chain_last  = s.chain[`CHAIN_LAST];
    assign bus_dtack   = s.dtack;
    assign bus_berr    = s.berr;
    assign bus_rdata   = s.rdata;
    assign bcast_cmd   = s.bcast_cmd;

    event_skid u_skid (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (event_valid),
        .in_data   (event_data),
        .in_ready  (event_ready),
        .out_valid (skid_valid),
        .out_data  (skid_data),
        .out_ready (skid_ready)
    );

    // ----------------------------------------
    // bus decode and next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.dtack = 1'b0;
        next_s.berr = 1'b0;
        next_s.bcast_cmd = 4'h0;
        pop = 1'b0;
        push_test = 1'b0;
        if (!pending)
            next_s.ack_hold = 1'b0;
        if (iack_hit) begin
            next_s.rdata = {24'h000000, s.irq_ctl[7:0]};
            next_s.dtack = 1'b1;
            next_s.ack_hold = 1'b1;
        end else if (bus_req) begin
            if (chain_hit) begin
                if (!fifo_empty) begin
                    next_s.rdata = fifo_head;
                    next_s.dtack = 1'b1;
                    pop = 1'b1;
                end else if (s.chain[`CHAIN_LAST]) begin
                    next_s.berr = 1'b1;
                end
            end else if (bc_hit) begin
                next_s.bcast_cmd = 4'h1 << offset[3:2];
                next_s.dtack = s.bc_hs;
            end else if (local_hit && win_hit) begin
                next_s.dtack = 1'b1;
                if (bus_write) begin
                    push_test = s.test_mode && !fifo_full;
                end else if (bus_d16 && !s.d16_second) begin
                    next_s.rdata = {16'h0000, fifo_head[31:16]};
                    next_s.d16_second = !fifo_empty;
                end else begin
                    next_s.rdata = bus_d16 ? {16'h0000, fifo_head[15:0]} : fifo_head;
                    next_s.d16_second = 1'b0;
                    pop = !fifo_empty;
                end
            end else if (local_hit) begin
                next_s.dtack = 1'b1;
                unique case (offset)
                    `OFS_CONTROL: begin
                        if (bus_write) begin
                            next_s.test_mode = jk(s.test_mode, bus_wdata[`CTL_TEST_ON], bus_wdata[`CTL_TEST_OFF]);
                            next_s.bc_en = jk(s.bc_en, bus_wdata[`CTL_BC_EN], bus_wdata[`CTL_BC_EN_OFF]);
                            next_s.bc_hs = jk(s.bc_hs, bus_wdata[`CTL_BC_HS], bus_wdata[`CTL_BC_HS_OFF]);
                            for (int i = 0; i < 4; i++) begin
                                next_s.src_en[i] = jk(s.src_en[i], bus_wdata[`CTL_SRC_ON_LSB + i],
                                                      bus_wdata[`CTL_SRC_OFF_LSB + i]);
                            end
                        end else begin
                            next_s.rdata = status_word;
                        end
                    end
                    `OFS_IRQ: begin
                        if (bus_write)
                            next_s.irq_ctl = bus_wdata[11:0];
                        else
                            next_s.rdata = {MODULE_ID, FW_VERSION, s.irq_ctl};
                    end
                    `OFS_CHAIN: begin
                        if (bus_write)
                            next_s.chain = bus_wdata & `CHAIN_MASK;
                        else
                            next_s.rdata = s.chain;
                    end
                    default: begin
                        next_s.dtack = 1'b0;
                    end
                endcase
            end
        end
        push = push_test || (skid_valid && skid_ready);
        push_word = push_test ? bus_wdata : skid_data;
        if (pop)
            next_s.rd_ptr = s.rd_ptr + 6'h01;
        if (push)
            next_s.wr_ptr = s.wr_ptr + 6'h01;
        next_s.count = s.count + {6'h00, push} - {6'h00, pop};
        if (next_s.bcast_cmd[0]) begin
            next_s.count = 7'h00;
            next_s.rd_ptr = 6'h00;
            next_s.wr_ptr = 6'h00;
            next_s.d16_second = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    // storage has no reset; pointers define what is valid
    always_ff @(posedge clk) begin
        if (push)
            fifo_mem[s.wr_ptr] <= push_word;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chain_reserved_a: assert property ((s.chain & ~`CHAIN_MASK) == 32'h00000000)
        else $error("reserved chain setup bits not zero");
    chain_gate_a: assert property (bus_berr |-> $past(s.chain[`CHAIN_ENABLE]) && $past(s.chain[`CHAIN_LAST]))
        else $error("chain termination without enable and last");
    fifo_pop_a: assert property ((bus_req && !bus_write && !bus_d16 && local_hit && win_hit && !chain_hit
                                  && !iack_hit && !fifo_empty && !push) |=> s.count == $past(s.count) - 7'h01)
        else $error("fifo read did not remove one word");
    irq_gate_a: assert property (irq_request |-> s.irq_ctl[`IRQ_GLOBAL] && irq_flag)
        else $error("request without global enable or source");
    irq_flag_a: assert property ((pending && !s.irq_ctl[`IRQ_GLOBAL]) |-> irq_flag && !irq_request)
        else $error("internal flag wrong while requests disabled");
    iack_vector_a: assert property (iack_hit |=> bus_dtack && bus_rdata == {24'h000000, $past(s.irq_ctl[7:0])})
        else $error("acknowledge vector not driven");
    roak_release_a: assert property (iack_hit |=> !irq_request)
        else $error("request not released on acknowledge");
    bcast_hs_a: assert property ((bcast_cmd != 4'h0) |-> bus_dtack == $past(s.bc_hs))
        else $error("broadcast handshake by wrong module");
    bcast_version_a: assert property (FW_VERSION != 4'h1 |-> bcast_cmd == 4'h0)
        else $error("broadcast in firmware version two");
    d16_first_a: assert property ((bus_req && !bus_write && bus_d16 && local_hit && win_hit && !chain_hit
                                   && !iack_hit && !s.d16_second && !fifo_empty)
                                  |=> bus_rdata == {16'h0000, $past(fifo_head[31:16])} && s.d16_second)
        else $error("16-bit first read not high half");
endmodule

// ===== sim/bus_master_model.sv
// Purpose: bus master issuing one transfer per call
// Assumes: answer registered at the taking edge, read 1 ns after it
// Notes:   address and data lines are inverted once released
`timescale 1ns/100ps
module bus_master_model (
    input  wire logic        clk,
    output logic             bus_req,
    output logic             bus_write,
    output logic             bus_d16,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_wdata,
    input  wire logic        bus_dtack,
    input  wire logic        bus_berr,
    input  wire logic [31:0] bus_rdata,
    output logic             iack_req,
    output logic [2:0]       iack_level
);
    initial begin
        bus_req = 1'b0;
        iack_req = 1'b0;
        bus_write = 1'b0;
        bus_d16 = 1'b0;
        bus_addr = 32'h0;
        bus_wdata = 32'h0;
        iack_level = 3'h0;
    end

    // ----------------------------------------
    // one transfer, held until the answer edge
    // ----------------------------------------
    task automatic xfer(input logic w, d16, ia, input logic [31:0] a, wd,
                        output logic ack, err, output logic [31:0] rd);
        @(posedge clk);
        #5;
        bus_req = ~ia;
        iack_req = ia;
        bus_write = w;
        bus_d16 = d16;
        bus_addr = a;
        bus_wdata = wd;
        iack_level = a[2:0];
        @(posedge clk);
        #1;
        ack = bus_dtack;
        err = bus_berr;
        rd = bus_rdata;
        #4;
        bus_req = 1'b0;
        iack_req = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~wd;
    endtask
endmodule

// ===== sim/test_latch_readout_port.sv
// Purpose: self-checking bench of the readout port
// Assumes: module base 0x32001000, default version
// Notes:   a second instance runs as version two
`timescale 1ns/100ps
module test_latch_readout_port;
    logic        clk, reset, event_valid, copy_in_progress, hs;
    logic        bus_req, bus_write, bus_d16, bus_dtack, bus_berr, iack_req;
    logic        irq_request, irq_flag, event_ready, ack, err;
    logic        fifo_empty, fifo_half, fifo_almost, fifo_full, chain_first, chain_last;
    logic [2:0]  iack_level, irq_level;
    logic [3:0]  bcast_cmd, bcast_cmd_v2;
    logic [19:0] base_addr;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, event_data, rdv;
    int          fails, check_count, src_left;

    latch_readout_port latch_readout_port_inst (.*);
    latch_readout_port #(.FW_VERSION(4'h2)) latch_readout_port_inst2 (.*, .bus_dtack(), .bus_berr(),
        .bus_rdata(), .irq_request(), .irq_level(), .irq_flag(), .event_ready(), .fifo_empty(),
        .fifo_half(), .fifo_almost(), .fifo_full(), .chain_first(), .chain_last(), .bcast_cmd(bcast_cmd_v2));
    bus_master_model bus_master_model_inst (.*);

    // ----------------------------------------
    // clock and event source
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // handshake judged mid-cycle, where ready has settled
    always @(negedge clk)
        hs = event_valid & event_ready;
    always @(posedge clk) begin
        if (hs === 1'b1) begin
            #5;
            event_data = event_data + 32'h1;
            src_left--;
            if (src_left == 0) begin
                event_valid = 1'b0;
                event_data = ~event_data;
            end
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc(input logic w, d16, ia, input logic [31:0] a, wd);
        bus_master_model_inst.xfer(w, d16, ia, a, wd, ack, err, rdv);
    endtask
    task automatic wr(input logic [11:0] o, input logic [31:0] d);
        acc(1'b1, 1'b0, 1'b0, {20'h32001, o}, d);
        check("write ack", ack, 1'b1);
    endtask
    task automatic rd(input logic [11:0] o, input logic d16, input logic [31:0] e);
        acc(1'b0, d16, 1'b0, {20'h32001, o}, 32'h0);
        check("read ack", ack, 1'b1);
        check("read data", rdv, e);
    endtask
    task automatic stream(input logic [31:0] d, input int n);
        event_data = d;
        src_left = n;
        event_valid = 1'b1;
    endtask
    task automatic wait_src;
        int n;
        n = 0;
        while (src_left > 0 && n < 200) begin
            @(posedge clk);
            #5;
            n++;
        end
        if (n == 200) begin
            fails++;
            end_of_test();
        end
        repeat (3) @(posedge clk);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        base_addr = 20'h32001;
        event_valid = 1'b0;
        event_data = 32'h0;
        copy_in_progress = 1'b0;
        fails = 0;
        check_count = 0;
        src_left = 0;
        repeat (12) @(posedge clk);
        #5;
        reset = 1'b0;
        check("ready", event_ready, 1'b1);
        rd(12'h000, 1'b0, 32'h100);
        $display("test reset done");

        wr(12'h080, 32'hFFFFFFFF);
        rd(12'h080, 1'b0, 32'hFF00F807);
        check("first", chain_first, 1'b1);
        check("last", chain_last, 1'b1);
        wr(12'h080, 32'h1200A003);
        rd(12'h080, 1'b0, 32'h1200A003);
        acc(1'b0, 1'b0, 1'b0, 32'h12000100, 32'h0);
        check("chain end", {ack, err}, 2'b01);
        acc(1'b0, 1'b0, 1'b0, 32'h13000100, 32'h0);
        check("chain miss", {ack, err}, 2'b00);
        wr(12'h080, 32'h12000002);
        acc(1'b0, 1'b0, 1'b0, 32'h12000100, 32'h0);
        check("chain off", {ack, err}, 2'b00);
        $display("test chain done");

        stream(32'hA1B2C3D4, 3);
        wait_src();
        rd(12'h100, 1'b1, 32'h0000A1B2);
        rd(12'h1FC, 1'b1, 32'h0000C3D4);
        rd(12'h180, 1'b0, 32'hA1B2C3D5);
        rd(12'h104, 1'b0, 32'hA1B2C3D6);
        check("drained", fifo_empty, 1'b1);
        $display("test readout done");

        wr(12'h100, 32'hDEAD0000);
        check("no push", fifo_empty, 1'b1);
        wr(12'h000, 32'h2);
        for (int i = 0; i < 64; i++) begin
            wr(12'h100 + 12'(i * 4), 32'h100 + i);
            check("half", fifo_half, 1'(i >= 31));
            check("almost", fifo_almost, 1'(i >= 55));
            check("full", fifo_full, 1'(i == 63));
        end
        wr(12'h1FC, 32'hBAD);
        $display("test fill done");

        wr(12'h004, 32'h3A5);
        rd(12'h004, 1'b0, {16'h1234, 4'h1, 12'h3A5});
        copy_in_progress = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, 32'h1 << (20 + i));
            check("flag on", irq_flag, 1'b1);
            check("no request", irq_request, 1'b0);
            wr(12'h000, 32'h1 << (28 + i));
            check("flag off", irq_flag, 1'b0);
        end
        copy_in_progress = 1'b0;
        wr(12'h004, 32'hBA5);
        wr(12'h000, 32'h1 << 23);
        check("request", irq_request, 1'b1);
        check("level", irq_level, 3'h3);
        acc(1'b0, 1'b0, 1'b1, 32'h3, 32'h0);
        check("vector ack", ack, 1'b1);
        check("vector", rdv, 32'hA5);
        @(posedge clk);
        #5;
        check("released", irq_request, 1'b0);
        wr(12'h000, 32'h1 << 31);
        check("cleared", irq_flag, 1'b0);
        $display("test interrupt done");

        wr(12'h000, 32'h200);
        stream(32'hE0, 3);
        repeat (8) @(posedge clk);
        #5;
        check("stall", event_ready, 1'b0);
        check("held words", src_left, 1);
        for (int i = 0; i < 64; i++)
            rd(12'h100, 1'b0, 32'h100 + i);
        wait_src();
        for (int i = 0; i < 3; i++)
            rd(12'h100, 1'b0, 32'hE0 + i);
        check("empty", fifo_empty, 1'b1);
        $display("test buffer done");

        stream(32'h77, 1);
        wait_src();
        acc(1'b1, 1'b0, 1'b0, 32'h32000034, 32'h0);
        check("bc off", {ack, bcast_cmd}, 5'h00);
        wr(12'h000, 32'h40);
        acc(1'b1, 1'b0, 1'b0, 32'h32000034, 32'h0);
        check("bc no hs", {ack, bcast_cmd}, 5'h02);
        wr(12'h000, 32'hC0);
        acc(1'b1, 1'b0, 1'b0, 32'h33000034, 32'h0);
        check("bc class", {ack, bcast_cmd}, 5'h00);
        for (int k = 3; k >= 0; k--) begin
            acc(1'b1, 1'b0, 1'b0, 32'h32000030 + 4 * k, 32'h0);
            check("bc cmd", {ack, bcast_cmd}, {1'b1, 4'h1 << k});
            check("bc v2", bcast_cmd_v2, 4'h0);
        end
        check("bc clear", fifo_empty, 1'b1);
        $display("test broadcast done");
        end_of_test();
    end
endmodule
